//--- pkg/scrd_pkg.sv
// package: constants and types for the strap clock ratio decoder
package scrd_pkg;

    // strap and divider widths
    localparam int PLAT_STRAP_W = 4;
    localparam int CORE_STRAP_W = 5;
    localparam int DIV_W        = 5;

    // ratios are held in half units (ratio * 2)
    localparam int HALF_W = 5;

    // platform strap codes
    localparam logic [3:0] PLAT_CODE_2 = 4'h2;
    localparam logic [3:0] PLAT_CODE_3 = 4'h3;
    localparam logic [3:0] PLAT_CODE_4 = 4'h4;
    localparam logic [3:0] PLAT_CODE_5 = 4'h5;
    localparam logic [3:0] PLAT_CODE_6 = 4'h6;
    localparam logic [3:0] PLAT_CODE_8 = 4'h8;
    localparam logic [3:0] PLAT_CODE_9 = 4'h9;

    // core strap codes
    localparam logic [4:0] CORE_CODE_2_0 = 5'h08;
    localparam logic [4:0] CORE_CODE_2_5 = 5'h0C;
    localparam logic [4:0] CORE_CODE_3_0 = 5'h10;
    localparam logic [4:0] CORE_CODE_3_5 = 5'h1C;
    localparam logic [4:0] CORE_CODE_4_0 = 5'h14;
    localparam logic [4:0] CORE_CODE_4_5 = 5'h0E;

    // values after reset
    localparam logic [HALF_W-1:0] HALF_RST = 5'h00;
    localparam logic [3:0]        CODE_RST = 4'h0;
    localparam logic [1:0]        MEM_DIV_RST = 2'h2;

    // frequency windows in MHz
    localparam int MEM_MIN_MHZ    = 200;
    localparam int MEM_MAX_MHZ    = 300;
    localparam int PLAT_LOW_MHZ   = 400;
    localparam int PLAT_MIN_MHZ   = 500;
    localparam int PLAT_MAX_MHZ   = 600;
    localparam int CORE_MIN_MHZ   = 800;
    localparam int LBUS_MIN_MHZ   = 25;
    localparam int LBUS_MAX_MHZ   = 133;
    localparam int REF_MIN_MHZ    = 66;
    localparam int REF_MAX_MHZ    = 167;
    // fifo interface limits, platform divisor times ten
    localparam int FIFO_GMII_DIV10 = 42;
    localparam int FIFO_ENC_DIV10  = 32;

    // decoded ratio bundle
    typedef struct packed {
        logic [HALF_W-1:0] plat_half;  // platform:reference * 2
        logic [HALF_W-1:0] core_half;  // core:platform * 2
        logic              plat_bad;
        logic              core_bad;
    } scrd_ratio_t;

endpackage

//--- src/scrd_top.sv
// strap clock ratio decoder: captures straps and publishes clock ratios
// What this block does
// - capture four platform strap inputs once at power-up, hold all session
// - decode platform strap 2,3,4,5,6,8,9; 0000,0001,0111 and 1010-1111 reserved
// - no default platform ratio; straps must be actively driven at power-up
// - memory clock runs at half the platform clock, 200 to 300 MHz
// - decode five-bit core strap into ratios 2 to 4.5
// - local bus clock is platform divided by programmed divider, 25-133 MHz; the divider is forwarded unchecked, zero included
`timescale 1ns/100ps
module scrd_top
    import scrd_pkg::*;
(
    // clock and reset
    input  wire logic                    core_clk_i,
    input  wire logic                    rst_i,
    // board straps
    input  wire logic [PLAT_STRAP_W-1:0] platform_ratio_strap_i,
    input  wire logic [3:0]              core_ratio_strap_high_i,
    input  wire logic                    core_ratio_strap_low_i,
    // software divider for the local bus clock
    input  wire logic [DIV_W-1:0]        local_clock_divider_i,
    // decoded settings
    output logic                         cfg_valid_o,
    output logic [HALF_W-1:0]            plat_ratio_half_o,
    output logic [HALF_W-1:0]            core_ratio_half_o,
    output logic [1:0]                   mem_div_o,
    output logic [DIV_W-1:0]             local_div_o,
    output logic                         plat_err_o,
    output logic                         core_err_o,
    output logic                         cfg_err_o
);

    typedef enum logic [1:0] {ST_SYNC, ST_SAMPLE, ST_LOCKED} scrd_state_t;

    // sequencing
    scrd_state_t                state_q;
    logic [1:0]                 sync_cnt_q;
    logic                       sample_en;
    // strap synchronisers
    logic [CORE_STRAP_W-1:0]    core_raw;
    logic [PLAT_STRAP_W-1:0]    plat_s1_q;
    logic [PLAT_STRAP_W-1:0]    plat_s2_q;
    logic [CORE_STRAP_W-1:0]    core_s1_q;
    logic [CORE_STRAP_W-1:0]    core_s2_q;
    // captured settings
    scrd_ratio_t                ratio_d;
    scrd_ratio_t                ratio_q;
    logic                       valid_q;
    logic                       cfg_err_q;
    logic [1:0]                 mem_div_q;
    logic [DIV_W-1:0]           div_q;

    // platform:reference decode in half units, so every ratio is an integer;
    // reserved codes give ratio zero and raise the flag
    function automatic logic [HALF_W:0] plat_decode(
        input logic [3:0] code
    );
        unique case (code)
            PLAT_CODE_2: plat_decode = {1'b0, 5'h04};
            PLAT_CODE_3: plat_decode = {1'b0, 5'h06};
            PLAT_CODE_4: plat_decode = {1'b0, 5'h08};
            PLAT_CODE_5: plat_decode = {1'b0, 5'h0A};
            PLAT_CODE_6: plat_decode = {1'b0, 5'h0C};
            PLAT_CODE_8: plat_decode = {1'b0, 5'h10};
            PLAT_CODE_9: plat_decode = {1'b0, 5'h12};
            default:     plat_decode = {1'b1, HALF_RST};
        endcase
    endfunction

    // core:platform decode in half units
    function automatic logic [HALF_W:0] core_decode(
        input logic [4:0] code
    );
        unique case (code)
            CORE_CODE_2_0: core_decode = {1'b0, 5'h04};
            CORE_CODE_2_5: core_decode = {1'b0, 5'h05};
            CORE_CODE_3_0: core_decode = {1'b0, 5'h06};
            CORE_CODE_3_5: core_decode = {1'b0, 5'h07};
            CORE_CODE_4_0: core_decode = {1'b0, 5'h08};
            CORE_CODE_4_5: core_decode = {1'b0, 5'h09};
            default:       core_decode = {1'b1, HALF_RST};
        endcase
    endfunction

    // the core code is split over two pin groups; join them before syncing
    assign core_raw = {core_ratio_strap_high_i, core_ratio_strap_low_i};

    // straps are board levels: two flops before anything reads them
    // pins settle one by one, so a code may tear for a cycle; the wait
    // before sampling lets the last pin arrive before the code is used
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            plat_s1_q <= CODE_RST;
            plat_s2_q <= CODE_RST;
        end else begin
            plat_s1_q <= platform_ratio_strap_i;
            plat_s2_q <= plat_s1_q;
        end
    end

    // same two stages for the five core strap bits
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            core_s1_q <= 5'h00;
            core_s2_q <= 5'h00;
        end else begin
            core_s1_q <= core_raw;
            core_s2_q <= core_s1_q;
        end
    end

    // both decodes read only the second stage of each synchroniser
    // ratio_d starts from ratio_q so every field has a value on every path
    always_comb begin
        ratio_d = ratio_q;
        {ratio_d.plat_bad, ratio_d.plat_half} = plat_decode(plat_s2_q);
        {ratio_d.core_bad, ratio_d.core_half} = core_decode(core_s2_q);
    end

    // three edges in the sync state let both stages fill with settled
    // strap levels before the one sample is taken
    // the counter stops outside the sync state, so it cannot wrap
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            sync_cnt_q <= 2'h0;
        end else if (state_q == ST_SYNC) begin
            sync_cnt_q <= sync_cnt_q + 2'h1;
        end
    end

    // one sample per reset; the locked state is left only through reset
    // the fourth code of the state type is unreachable, so no default item
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_q <= ST_SYNC;
        end else begin
            unique case (state_q)
                ST_SYNC: begin
                    if (sync_cnt_q == 2'h2) begin
                        state_q <= ST_SAMPLE;
                    end
                end
                ST_SAMPLE: begin
                    state_q <= ST_LOCKED;
                end
                ST_LOCKED: begin
                    state_q <= ST_LOCKED;
                end
            endcase
        end
    end

    assign sample_en = (state_q == ST_SAMPLE);

    // ratios are captured once; strap moves after that are ignored, so a
    // board that changes straps later must reset the block to reload them
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            ratio_q <= '0;
        end else if (sample_en) begin
            ratio_q <= ratio_d;
        end
    end

    // error flag loads with the ratios so it never leads or lags them
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cfg_err_q <= 1'b0;
        end else if (sample_en) begin
            cfg_err_q <= ratio_d.plat_bad | ratio_d.core_bad;
        end
    end

    // valid rises on the same edge as the ratios it qualifies
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            valid_q <= 1'b0;
        end else if (sample_en) begin
            valid_q <= 1'b1;
        end
    end

    // memory clock is always half the platform clock, even in reset;
    // held in a flop so the output is registered like the other settings
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            mem_div_q <= MEM_DIV_RST;
        end else begin
            mem_div_q <= MEM_DIV_RST;
        end
    end

    // divider is live; a zero divider is passed on as a stopped local clock
    // and range limits on the result are the programming side's concern
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            div_q <= '0;
        end else begin
            div_q <= local_clock_divider_i;
        end
    end

    // settings seen by the clock generators
    assign cfg_valid_o       = valid_q;
    assign plat_ratio_half_o = ratio_q.plat_half;
    assign core_ratio_half_o = ratio_q.core_half;
    assign mem_div_o         = mem_div_q;
    assign local_div_o       = div_q;
    assign plat_err_o        = ratio_q.plat_bad;
    assign core_err_o        = ratio_q.core_bad;
    assign cfg_err_o         = cfg_err_q;

endmodule // scrd_top

//--- tb/scrd_assertions.sv
// concurrent checks on the strap clock ratio decoder ports
`timescale 1ns/100ps
module scrd_assertions
    import scrd_pkg::*;
(
    input wire logic              core_clk_i,
    input wire logic              rst_i,
    input wire logic [DIV_W-1:0]  local_clock_divider_i,
    input wire logic              cfg_valid_o,
    input wire logic [HALF_W-1:0] plat_ratio_half_o,
    input wire logic [HALF_W-1:0] core_ratio_half_o,
    input wire logic [1:0]        mem_div_o,
    input wire logic [DIV_W-1:0]  local_div_o,
    input wire logic              plat_err_o,
    input wire logic              core_err_o,
    input wire logic              cfg_err_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    AST_MEM_HALF: assert property (mem_div_o == 2'h2)
        else $error("memory divider not two");
    AST_HOLD: assert property (cfg_valid_o && $past(cfg_valid_o) |->
        $stable(plat_ratio_half_o) && $stable(core_ratio_half_o))
        else $error("ratios moved after capture");
    // straps pass a two flop sync first, so capture cannot be immediate
    AST_CAPTURE: assert property ($fell(rst_i) |->
        !cfg_valid_o [*3] ##[1:6] cfg_valid_o)
        else $error("capture not in its window");
    AST_LDIV: assert property (!$past(rst_i) |->
        local_div_o == $past(local_clock_divider_i))
        else $error("local divider not forwarded");
    AST_ERR_OR: assert property (cfg_err_o == (plat_err_o | core_err_o))
        else $error("config error not the or");
    AST_PLAT: assert property (cfg_valid_o |->
        plat_err_o == (plat_ratio_half_o == 5'h00) &&
        plat_ratio_half_o inside {5'h00, 5'h04, 5'h06, 5'h08, 5'h0A,
                                  5'h0C, 5'h10, 5'h12})
        else $error("platform ratio bad");
    AST_CORE: assert property (cfg_valid_o |->
        core_err_o == (core_ratio_half_o == 5'h00) &&
        core_ratio_half_o inside {[5'h04:5'h09], 5'h00})
        else $error("core ratio bad");
    AST_IDLE: assert property (!cfg_valid_o |-> !cfg_err_o)
        else $error("error before capture");
endmodule // scrd_assertions

bind scrd_top scrd_assertions chk_u (.*);

//--- tb/scrd_strap_model.sv
// board strap network feeding the decoder
`timescale 1ns/100ps
module scrd_strap_model
    import scrd_pkg::*;
(
    // requested setting
    input  wire logic [3:0] plat_code_i,
    input  wire logic [4:0] core_code_i,
    // strap pins, every one actively driven
    output logic [3:0]      plat_strap_o,
    output logic [3:0]      core_high_o,
    output logic            core_low_o,
    // board-side view of whether the chosen setting is allowed
    output logic            legal_o
);
    // reference and fifo interface clocks this board would fit
    localparam int REF_MHZ  = 66;
    localparam int FIFO_MHZ = 125;
    int plat_mhz;
    assign plat_mhz = REF_MHZ * plat_code_i;
    assign plat_strap_o = plat_code_i;
    assign {core_high_o, core_low_o} = core_code_i;
    // lowest core ratio is two, so twice the platform bounds the core clock
    assign legal_o = (REF_MHZ >= REF_MIN_MHZ && REF_MHZ <= REF_MAX_MHZ)
        && (plat_mhz == PLAT_LOW_MHZ || (plat_mhz >= PLAT_MIN_MHZ
        && plat_mhz <= PLAT_MAX_MHZ))
        && plat_mhz * 2 >= CORE_MIN_MHZ
        && plat_mhz / 2 >= MEM_MIN_MHZ && plat_mhz / 2 <= MEM_MAX_MHZ
        && FIFO_MHZ * FIFO_GMII_DIV10 <= plat_mhz * 10
        && FIFO_MHZ * FIFO_ENC_DIV10 <= plat_mhz * 10;
endmodule // scrd_strap_model

//--- tb/scrd_top_tb.sv
// self-checking testbench for the strap clock ratio decoder
`timescale 1ns/100ps
module scrd_top_tb
    import scrd_pkg::*;
;
    logic clk = 0, rst = 1, vld, pe, ce, fe, cl, lg;
    logic [3:0] pc = 4'h0, ps, ch;
    logic [4:0] cc = 5'h00, dv = 5'h00, ph, cr, ld;
    logic [1:0] md;
    int failures = 0, n_compared = 0;
    always #5 clk = ~clk;
    scrd_strap_model board_u (.plat_code_i(pc), .core_code_i(cc),
        .plat_strap_o(ps), .core_high_o(ch), .core_low_o(cl),
        .legal_o(lg));
    scrd_top dut_u (.core_clk_i(clk), .rst_i(rst),
        .platform_ratio_strap_i(ps), .core_ratio_strap_high_i(ch),
        .core_ratio_strap_low_i(cl), .local_clock_divider_i(dv),
        .cfg_valid_o(vld), .plat_ratio_half_o(ph), .core_ratio_half_o(cr),
        .mem_div_o(md), .local_div_o(ld), .plat_err_o(pe),
        .core_err_o(ce), .cfg_err_o(fe));
    function automatic logic [4:0] e_core(logic [4:0] c);
        case (c) 5'h08: return 5'h04; 5'h0C: return 5'h05;
            5'h10: return 5'h06; 5'h1C: return 5'h07; 5'h14: return 5'h08;
            5'h0E: return 5'h09; default: return 5'h00; endcase
    endfunction
    task automatic chk(input string n, input logic [7:0] s, e);
        n_compared++;
        if (s !== e) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic capture(input logic [3:0] p, input logic [4:0] c);
        int k = 0;
        @(posedge clk); rst <= 1'b1; pc <= p; cc <= c;
        @(posedge clk); rst <= 1'b0;
        while (vld !== 1'b1 && k < 20) begin @(posedge clk); #1; k++; end
    endtask
    task automatic sc_decode();
        logic [4:0] ep, ec;
        for (int i = 0; i < 32; i++) begin
            capture(i[3:0], i[4:0]);
            ep = (i[3:0] inside {2, 3, 4, 5, 6, 8, 9}) ? {i[3:0], 1'b0} : 0;
            ec = e_core(i[4:0]);
            chk("valid", vld, 1);
            chk("plat", ph, ep);
            chk("core", cr, ec);
            chk("perr", pe, ep == 0);
            chk("cerr", ce, ec == 0);
            chk("err", fe, ep == 0 || ec == 0);
            chk("mem", md, 2);
        end
    endtask
    task automatic sc_hold();
        capture(4'h9, 5'h0E);
        chk("board legal", lg, 1);
        @(posedge clk); pc <= 4'h7; cc <= 5'h00;
        repeat (4) @(posedge clk);
        #1 chk("hold plat", ph, 5'h12);
        chk("hold core", cr, 5'h09);
        chk("board illegal", lg, 0);
        @(posedge clk); rst <= 1'b1;
        @(posedge clk); #1 chk("rst valid", vld, 0);
        chk("rst mem", md, 2);
        chk("rst plat", ph, 0);
        @(posedge clk); rst <= 1'b0;
        repeat (3) @(posedge clk);
        #1 chk("early valid", vld, 0);
        @(posedge clk); #1 chk("late valid", vld, 1);
        chk("late err", fe, 1);
    endtask
    task automatic sc_div();
        // the extremes plus a mid value; zero passes through as is
        logic [4:0] vals [3] = '{5'h00, 5'h1F, 5'h07};
        foreach (vals[j]) begin
            @(posedge clk); dv <= vals[j];
            @(posedge clk); #1 chk("ldiv", ld, vals[j]);
        end
    endtask
    task automatic complete_run();
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        sc_decode();
        sc_hold();
        sc_div();
        complete_run();
    end
    initial begin
        #100000;
        failures++;
        complete_run();
    end
endmodule // scrd_top_tb
